// ---- anv_pkg.sv ----
// Package: register map, reset values, field positions, timing and shared types.
package anv_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int AW = 6;
   localparam int RW = 16;
   localparam logic [AW-1:0] OFF_ATTEN = 6'h0F;
   localparam logic [AW-1:0] OFF_N2A = 6'h14;
   localparam logic [AW-1:0] OFF_N2B = 6'h15;
   localparam logic [AW-1:0] OFF_N3A = 6'h16;
   localparam logic [AW-1:0] OFF_N3B = 6'h17;
   localparam logic [AW-1:0] OFF_LIMITS = 6'h20;
   localparam logic [AW-1:0] OFF_TARGET = 6'h21;
   localparam logic [AW-1:0] OFF_RATES = 6'h22;
   localparam logic [AW-1:0] OFF_STATUS = 6'h23;

   // ----------------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_ATTEN = 8'hFF;
   localparam logic [RW-1:0] RST_COEF = 16'h0000;
   localparam logic [8:0] RST_LIMITS = 9'h038;
   localparam logic [3:0] RST_TARGET = 4'hB;
   localparam logic [8:0] RST_RATES = 9'h032;
   localparam logic [5:0] RST_GAIN = 6'h10;
   localparam int COMMIT_BIT = 15;
   localparam int ON_BIT = 14;
   localparam int COEF_MSB = 13;
   localparam int SIGN_BIT = 13;
   localparam int LVL_ON_BIT = 8;
   localparam int MODE_BIT = 8;
   localparam int FLOOR_LSB = 0;
   localparam int CEIL_LSB = 3;
   localparam int DCY_LSB = 4;
   localparam int ATK_LSB = 0;
   localparam logic [3:0] RATE_SAT = 4'hA;
   localparam int A0_SH = 13;
   localparam int A1_SH = 12;
   localparam int FRAC_SH = 15;
   localparam logic [7:0] ATT_STEPS_PER_6DB = 8'h0C;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int ATK_NORM_NS = 104000;
   localparam int DCY_NORM_NS = 410000;
   localparam int ATK_LIM_NS = 22700;
   localparam int DCY_LIM_NS = 90800;
   localparam int ATK_NORM_CYC = ATK_NORM_NS / CLK_NS;
   localparam int DCY_NORM_CYC = DCY_NORM_NS / CLK_NS;
   localparam int ATK_LIM_CYC = ATK_LIM_NS / CLK_NS;
   localparam int DCY_LIM_CYC = DCY_LIM_NS / CLK_NS;

   // ----------------------------------------------------------------------
   // Tables
   // ----------------------------------------------------------------------
   // Linear full-scale threshold per target code, 1.5 dB per step; codes 14 and 15 share one value.
   localparam logic [15:0] THR [16] = '{16'h0999, 16'h0B68, 16'h0D8E, 16'h101D,
      16'h1326, 16'h16C3, 16'h1B0C, 16'h2027, 16'h2635, 16'h2D6A, 16'h35FA,
      16'h4027, 16'h4C40, 16'h5A9D, 16'h6BB3, 16'h6BB3};
   // Q15 gain of 0 to -5.5 dB in 0.5 dB steps; whole 6 dB steps are shifts.
   localparam logic [15:0] FRAC [12] = '{16'h8000, 16'h78D1, 16'h7209, 16'h6BA2,
      16'h6598, 16'h5FE4, 16'h5A82, 16'h556E, 16'h50A3, 16'h4C1C, 16'h47D6,
      16'h43CE};

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic signed [15:0] data;
   } anv_samp_t;

   typedef struct packed {
      logic [13:0] a0;
      logic [13:0] a1;
   } anv_coef_t;

endpackage

// ---- anv_section.sv ----
// Filter section: notch, or first-order low-pass, on sign/magnitude coefficients.
`timescale 1ns/1ps
`default_nettype none
module anv_section #(
   parameter int IW = 24
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic enable_in,
   input wire logic lowpass_in,
   input wire anv_pkg::anv_coef_t coef_in,
   input wire anv_pkg::anv_samp_t samp_in,
   output anv_pkg::anv_samp_t samp_out
);
   localparam logic signed [IW-1:0] MAXV = IW'(32'sh00007FFF);
   localparam logic signed [IW-1:0] MINV = IW'(32'shFFFF8000);

   function automatic logic signed [14:0] sm_to_int(input logic [13:0] v);
      logic signed [14:0] mag;
      mag = signed'({2'h0, v[12:0]});
      return v[anv_pkg::SIGN_BIT] ? -mag : mag;
   endfunction

   logic signed [14:0] c0, c1;
   logic signed [IW-1:0] st1_ff, st2_ff, nxt_st1, nxt_st2, xe, w, ap, y;
   logic signed [IW+14:0] p_a, p_b, p_c;
   logic signed [15:0] y_sat;

   assign c0 = sm_to_int(coef_in.a0);
   assign c1 = sm_to_int(coef_in.a1);

   // ----------------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------------
   // Registers hold -a0 scaled by 2^13 and -a1 scaled by 2^12, so signs fold in.
   always_comb begin
      xe = IW'($signed(samp_in.data));
      w = '0;
      p_c = '0;
      if (lowpass_in) begin
         p_a = c1 * xe;
         p_b = c1 * st2_ff;
         ap = st1_ff - IW'(p_a >>> anv_pkg::A1_SH) + IW'(p_b >>> anv_pkg::A1_SH);
         nxt_st1 = xe;
         nxt_st2 = ap;
      end else begin
         p_a = c1 * st1_ff;
         p_b = c0 * st2_ff;
         w = xe + IW'(p_a >>> anv_pkg::A1_SH) + IW'(p_b >>> anv_pkg::A0_SH);
         p_c = c0 * w;
         ap = st2_ff - IW'(p_c >>> anv_pkg::A0_SH) - IW'(p_a >>> anv_pkg::A1_SH);
         nxt_st1 = w;
         nxt_st2 = st1_ff;
      end
      y = (xe + ap) >>> 1;
      if (y > MAXV) begin
         y_sat = 16'sh7FFF;
      end else if (y < MINV) begin
         y_sat = 16'sh8000;
      end else begin
         y_sat = y[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // State and output
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st1_ff <= '0;
         st2_ff <= '0;
      end else if (ce_in && samp_in.valid) begin
         if (enable_in) begin
            st1_ff <= nxt_st1;
            st2_ff <= nxt_st2;
         end else begin
            st1_ff <= '0;
            st2_ff <= '0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         samp_out <= '0;
      end else if (ce_in) begin
         samp_out.valid <= samp_in.valid;
         if (samp_in.valid) begin
            samp_out.data <= enable_in ? y_sat : samp_in.data;
         end
      end
   end

   bypass_path_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (ce_in && samp_in.valid && !enable_in) |=> (samp_out.data == $past(samp_in.data))
   ) else $error("Disabled section did not pass the sample through.");

   sign_mag_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (c1 < 0) == (coef_in.a1[13] && coef_in.a1[12:0] != 13'h0000)
   ) else $error("Coefficient sign does not follow the sign bit.");

endmodule // anv_section
`default_nettype wire

// ---- anv_top.sv ----
// Top level: notch filter two, notch or low-pass filter three, digital attenuator and level control.
`timescale 1ns/1ps
`default_nettype none
module anv_top #(
   parameter logic [23:0] ATK_NORM_CYC = 24'(anv_pkg::ATK_NORM_CYC),
   parameter logic [23:0] DCY_NORM_CYC = 24'(anv_pkg::DCY_NORM_CYC),
   parameter logic [23:0] ATK_LIM_CYC = 24'(anv_pkg::ATK_LIM_CYC),
   parameter logic [23:0] DCY_LIM_CYC = 24'(anv_pkg::DCY_LIM_CYC)
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   input wire anv_pkg::anv_samp_t samp_in,
   output anv_pkg::anv_samp_t samp_out,
   input wire logic [5:0] manual_gain_in,
   output logic [5:0] pga_gain_out
);
   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic rst_meta_ff, rst_sync_ff, rst_n;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign rst_n = rst_sync_ff;

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic strobe, input logic [5:0] addr,
                                input logic [5:0] off);
      return strobe && (addr == off);
   endfunction

   function automatic logic [5:0] clamp(input logic [5:0] g, input logic [5:0] lo,
                                        input logic [5:0] hi);
      if (g < lo) begin
         return lo;
      end
      if (g > hi) begin
         return hi;
      end
      return g;
   endfunction

   function automatic logic [23:0] step_len(input logic [23:0] base, input logic [3:0] code);
      return base << ((code > anv_pkg::RATE_SAT) ? anv_pkg::RATE_SAT : code);
   endfunction

   logic [7:0] atten_ff;
   logic [15:0] n2a_ff, n2b_ff, n3a_ff, n3b_ff;
   logic [15:0] nxt_n2a, nxt_n2b, nxt_n3a, nxt_n3b;
   logic [8:0] limits_ff, rates_ff;
   logic [3:0] target_ff;
   logic [15:0] rdata_ff, nxt_rdata;
   logic [5:0] gain_ff;
   logic [15:0] peak_ff;
   logic [23:0] tmr_ff;

   assign nxt_n2a = hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_N2A) ? reg_wdata_in : n2a_ff;
   assign nxt_n2b = hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_N2B) ? reg_wdata_in : n2b_ff;
   assign nxt_n3a = hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_N3A) ? reg_wdata_in : n3a_ff;
   assign nxt_n3b = hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_N3B) ? reg_wdata_in : n3b_ff;

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         n2a_ff <= anv_pkg::RST_COEF;
         n2b_ff <= anv_pkg::RST_COEF;
         n3a_ff <= anv_pkg::RST_COEF;
         n3b_ff <= anv_pkg::RST_COEF;
      end else if (ce_in) begin
         n2a_ff <= nxt_n2a;
         n2b_ff <= nxt_n2b;
         n3a_ff <= nxt_n3a;
         n3b_ff <= nxt_n3b;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         atten_ff <= anv_pkg::RST_ATTEN;
         limits_ff <= anv_pkg::RST_LIMITS;
         target_ff <= anv_pkg::RST_TARGET;
         rates_ff <= anv_pkg::RST_RATES;
      end else if (ce_in) begin
         if (hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_ATTEN)) begin
            atten_ff <= reg_wdata_in[7:0];
         end
         if (hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_LIMITS)) begin
            limits_ff <= reg_wdata_in[8:0];
         end
         if (hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_TARGET)) begin
            target_ff <= reg_wdata_in[3:0];
         end
         if (hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_RATES)) begin
            rates_ff <= reg_wdata_in[8:0];
         end
      end
   end

   always_comb begin
      case (reg_addr_in)
         anv_pkg::OFF_ATTEN: nxt_rdata = {8'h00, atten_ff};
         anv_pkg::OFF_N2A: nxt_rdata = n2a_ff;
         anv_pkg::OFF_N2B: nxt_rdata = n2b_ff;
         anv_pkg::OFF_N3A: nxt_rdata = n3a_ff;
         anv_pkg::OFF_N3B: nxt_rdata = n3b_ff;
         anv_pkg::OFF_LIMITS: nxt_rdata = {7'h00, limits_ff};
         anv_pkg::OFF_TARGET: nxt_rdata = {12'h000, target_ff};
         anv_pkg::OFF_RATES: nxt_rdata = {7'h00, rates_ff};
         anv_pkg::OFF_STATUS: nxt_rdata = {10'h000, gain_ff};
         default: nxt_rdata = 16'h0000;
      endcase
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 16'h0000;
      end else if (ce_in) begin
         rdata_ff <= reg_rd_in ? nxt_rdata : 16'h0000;
      end
   end

   assign reg_rdata_out = rdata_ff;

   // ----------------------------------------------------------------------
   // Coefficient commit
   // ----------------------------------------------------------------------
   logic commit2, commit3;
   anv_pkg::anv_coef_t act2_ff, act3_ff;

   assign commit2 = reg_wr_in && reg_wdata_in[anv_pkg::COMMIT_BIT] &&
                    (reg_addr_in == anv_pkg::OFF_N2A || reg_addr_in == anv_pkg::OFF_N2B);
   assign commit3 = reg_wr_in && reg_wdata_in[anv_pkg::COMMIT_BIT] &&
                    (reg_addr_in == anv_pkg::OFF_N3A || reg_addr_in == anv_pkg::OFF_N3B);

   // The commit takes the value written in the same cycle, so one write can finish the pair.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         act2_ff <= '0;
         act3_ff <= '0;
      end else if (ce_in) begin
         if (commit2) begin
            act2_ff.a0 <= nxt_n2a[anv_pkg::COEF_MSB:0];
            act2_ff.a1 <= nxt_n2b[anv_pkg::COEF_MSB:0];
         end
         if (commit3) begin
            act3_ff.a0 <= nxt_n3a[anv_pkg::COEF_MSB:0];
            act3_ff.a1 <= nxt_n3b[anv_pkg::COEF_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Sample path
   // ----------------------------------------------------------------------
   anv_pkg::anv_samp_t mid_samp, post_samp, out_ff;
   logic filter_two_on, filter_three_on, filter_three_lowpass_sel;
   logic [7:0] att_steps;
   logic [4:0] att_shift;
   logic [3:0] att_idx;
   logic signed [32:0] att_prod, att_scaled;

   assign filter_two_on = n2a_ff[anv_pkg::ON_BIT];
   assign filter_three_on = n3a_ff[anv_pkg::ON_BIT];
   assign filter_three_lowpass_sel = n3b_ff[anv_pkg::ON_BIT];

   anv_section u_filter_two (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .ce_in(ce_in),
      .enable_in(filter_two_on),
      .lowpass_in(1'b0),
      .coef_in(act2_ff),
      .samp_in(samp_in),
      .samp_out(mid_samp)
   );

   anv_section u_filter_three (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .ce_in(ce_in),
      .enable_in(filter_three_on),
      .lowpass_in(filter_three_lowpass_sel),
      .coef_in(act3_ff),
      .samp_in(mid_samp),
      .samp_out(post_samp)
   );

   // Each 12 codes below full scale is one 6 dB shift; the rest is a table gain.
   always_comb begin
      att_steps = 8'hFF - atten_ff;
      att_shift = 5'(att_steps / anv_pkg::ATT_STEPS_PER_6DB);
      att_idx = 4'(att_steps % anv_pkg::ATT_STEPS_PER_6DB);
      att_prod = $signed(post_samp.data) * $signed({1'b0, anv_pkg::FRAC[att_idx]});
      att_scaled = (att_prod >>> anv_pkg::FRAC_SH) >>> att_shift;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= '0;
      end else if (ce_in) begin
         out_ff.valid <= post_samp.valid;
         if (post_samp.valid) begin
            out_ff.data <= (atten_ff == 8'h00) ? 16'sh0000 : att_scaled[15:0];
         end
      end
   end

   assign samp_out = out_ff;

   // ----------------------------------------------------------------------
   // Level control
   // ----------------------------------------------------------------------
   logic level_ctrl_on, level_ctrl_behaviour, over, tick;
   logic [5:0] floor_idx, ceil_idx;
   logic [15:0] samp_abs;
   logic [23:0] limit;

   assign level_ctrl_on = limits_ff[anv_pkg::LVL_ON_BIT];
   assign level_ctrl_behaviour = rates_ff[anv_pkg::MODE_BIT];
   assign floor_idx = {limits_ff[anv_pkg::FLOOR_LSB +: 3], 3'h0};
   assign ceil_idx = {limits_ff[anv_pkg::CEIL_LSB +: 3], 3'h7};
   assign samp_abs = samp_in.data[15] ? 16'(~samp_in.data) : 16'(samp_in.data);
   assign over = peak_ff > anv_pkg::THR[target_ff];
   assign limit = over ?
      step_len(level_ctrl_behaviour ? ATK_LIM_CYC : ATK_NORM_CYC,
               rates_ff[anv_pkg::ATK_LSB +: 4]) :
      step_len(level_ctrl_behaviour ? DCY_LIM_CYC : DCY_NORM_CYC,
               rates_ff[anv_pkg::DCY_LSB +: 4]);
   assign tick = level_ctrl_on && (tmr_ff >= limit - 24'h000001);

   // The peak holds the largest input magnitude since the last level-control tick, whether or not the gain stepped.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         peak_ff <= 16'h0000;
      end else if (ce_in) begin
         if (!level_ctrl_on) begin
            peak_ff <= 16'h0000;
         end else if (tick) begin
            peak_ff <= samp_in.valid ? samp_abs : 16'h0000;
         end else if (samp_in.valid && samp_abs > peak_ff) begin
            peak_ff <= samp_abs;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tmr_ff <= 24'h000000;
      end else if (ce_in) begin
         tmr_ff <= (tick || !level_ctrl_on) ? 24'h000000 : tmr_ff + 24'h000001;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         gain_ff <= anv_pkg::RST_GAIN;
      end else if (ce_in) begin
         if (!level_ctrl_on) begin
            gain_ff <= manual_gain_in;
         end else if (tick && over) begin
            gain_ff <= clamp((gain_ff > floor_idx) ? gain_ff - 6'h01 : floor_idx,
                             floor_idx, ceil_idx);
         end else if (tick) begin
            gain_ff <= clamp((gain_ff < ceil_idx) ? gain_ff + 6'h01 : ceil_idx,
                             floor_idx, ceil_idx);
         end else begin
            gain_ff <= clamp(gain_ff, floor_idx, ceil_idx);
         end
      end
   end

   assign pga_gain_out = gain_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   commit_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && hit(reg_wr_in, reg_addr_in, anv_pkg::OFF_N2B) && reg_wdata_in[15])
      |=> (act2_ff.a1 == n2b_ff[13:0] && act2_ff.a0 == n2a_ff[13:0])
   ) else $error("Commit did not load the filter two coefficients.");

   commit_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && !commit3) |=> $stable(act3_ff)
   ) else $error("Filter three coefficients changed without a commit.");

   mute_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && post_samp.valid && atten_ff == 8'h00) |=> (samp_out.data == 16'sh0000)
   ) else $error("Mute code did not silence the output.");

   unity_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && post_samp.valid && atten_ff == 8'hFF) |=> (samp_out.data == $past(post_samp.data))
   ) else $error("Full-scale code altered the sample.");

   gain_floor_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && level_ctrl_on && floor_idx <= ceil_idx) |=> (gain_ff >= $past(floor_idx))
   ) else $error("Gain fell below the floor.");

   gain_ceiling_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && level_ctrl_on && floor_idx <= ceil_idx) |=> (gain_ff <= $past(ceil_idx))
   ) else $error("Gain rose above the ceiling.");

   manual_gain_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (rst_n && ce_in && !level_ctrl_on) |=> (pga_gain_out == $past(manual_gain_in))
   ) else $error("Disabled level control did not pass the manual gain.");

   attack_step_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && tick && over && gain_ff > floor_idx && gain_ff <= ceil_idx)
      |=> (gain_ff == $past(gain_ff) - 6'h01)
   ) else $error("Gain did not step down above the target.");

   decay_step_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && tick && !over && gain_ff < ceil_idx && gain_ff >= floor_idx)
      |=> (gain_ff == $past(gain_ff) + 6'h01)
   ) else $error("Gain did not step up below the target.");

   attack_time_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ce_in && tick && over && !level_ctrl_behaviour && rates_ff[3:0] == 4'h0)
      |-> (tmr_ff >= ATK_NORM_CYC - 24'h000001)
   ) else $error("Attack step came at the wrong time.");

endmodule // anv_top
`default_nettype wire

// ---- anv_tb.sv ----
// Self-checking testbench for anv_top: registers, sample path, attenuator and level control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic [5:0] reg_addr_in = 6'h00;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [15:0] reg_rdata_out;
   anv_pkg::anv_samp_t samp_in = '0;
   anv_pkg::anv_samp_t samp_out;
   logic [5:0] manual_gain_in = 6'h05;
   logic [5:0] pga_gain_out;
   logic [15:0] rd_q[$];
   logic [15:0] smp_q[$];
   logic rd_pend = 1'b0;
   logic [15:0] lf = 16'h0050;
   logic [5:0] g0;
   logic [7:0] att_code [4] = '{8'hFF, 8'hF3, 8'hE7, 8'h00};
   logic [15:0] att_exp [4] = '{16'h4000, 16'h2000, 16'h1000, 16'h0000};
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   always #20 sys_clk_in = ~sys_clk_in;
   anv_top #(.ATK_NORM_CYC(24'h4), .DCY_NORM_CYC(24'h8), .ATK_LIM_CYC(24'h2),
      .DCY_LIM_CYC(24'h3)) uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .samp_in(samp_in),
      .samp_out(samp_out), .manual_gain_in(manual_gain_in), .pga_gain_out(pga_gain_out));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
         num_errors++;
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      rd_q.push_back(e);
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
   endtask
   task automatic snd(input logic [15:0] d, input logic [15:0] e);
      @(posedge sys_clk_in);
      samp_in <= '{valid: 1'b1, data: d};
      smp_q.push_back(e);
      @(posedge sys_clk_in);
      samp_in.valid <= 1'b0;
   endtask
   // -----------------------------------------------------------------------
   // Output watcher: read data and samples are compared with the oldest note.
   // -----------------------------------------------------------------------
   always @(posedge sys_clk_in) begin
      cycles++;
      if (rd_pend) `CHK(reg_rdata_out, rd_q.pop_front());
      else if (rst_n_in) `CHK(reg_rdata_out, 16'h0000);
      rd_pend <= reg_rd_in;
      if (samp_out.valid === 1'b1) `CHK($unsigned(samp_out.data), smp_q.pop_front());
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (4) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      rd(anv_pkg::OFF_ATTEN, 16'h00FF);
      rd(anv_pkg::OFF_N2A, 16'h0000);
      rd(anv_pkg::OFF_N3B, 16'h0000);
      rd(anv_pkg::OFF_TARGET, 16'h000B);
      rd(anv_pkg::OFF_LIMITS, 16'h0038);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         wr(anv_pkg::OFF_TARGET, lf);
         rd(anv_pkg::OFF_TARGET, {12'h000, lf[3:0]});
         wr(anv_pkg::OFF_N3B, lf);
         rd(anv_pkg::OFF_N3B, lf);
         wr(6'h3F, lf);
         rd(6'h3F, 16'h0000);
      end
      wr(anv_pkg::OFF_N3B, 16'h0000);
      wr(anv_pkg::OFF_TARGET, 16'h000B);
      snd(lf, lf);
      wr(anv_pkg::OFF_N3B, 16'h4800);
      wr(anv_pkg::OFF_N3A, 16'hC000);
      snd(16'h1000, 16'h0400);
      snd(16'h1000, 16'h0A00);
      wr(anv_pkg::OFF_N3A, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(anv_pkg::OFF_ATTEN, {8'h00, att_code[i]});
         snd(16'h4000, att_exp[i]);
      end
      manual_gain_in <= 6'h2A;
      repeat (3) @(posedge sys_clk_in);
      `CHK(pga_gain_out, 6'h2A);
      wr(anv_pkg::OFF_LIMITS, 16'h013F);
      repeat (3) @(posedge sys_clk_in);
      `CHK(pga_gain_out >= 6'h38, 1'b1);
      wr(anv_pkg::OFF_LIMITS, 16'h0100);
      repeat (3) @(posedge sys_clk_in);
      `CHK(pga_gain_out <= 6'h07, 1'b1);
      wr(anv_pkg::OFF_LIMITS, 16'h0138);
      g0 = pga_gain_out;
      repeat (200) @(posedge sys_clk_in);
      `CHK(pga_gain_out > g0, 1'b1);
      wr(anv_pkg::OFF_RATES, 16'h0030);
      g0 = pga_gain_out;
      for (int i = 0; i < 30; i++) snd(16'h7FFF, 16'h0000);
      `CHK(pga_gain_out < g0, 1'b1);
      repeat (5) @(posedge sys_clk_in);
      complete_run();
   end
endmodule // tb
`default_nettype wire
